/* design/bplk_protect.sv */
// Operation
// - Busy and re-enable bits have no function
// - Two lock fields, each set independently
// - Locks only program; chip erase restores them
// - One is unprogrammed, zero is programmed
// - App mode 1: no access restriction
// - App lower bit programmed: refuse app writes
// - App upper programmed: boot loads denied
// - Mask interrupts, vectors boot, running app
// - Boot mode 1: no access restriction
// - Boot lower bit programmed: refuse boot writes
// - Boot upper programmed: app loads denied
// - Mask interrupts, vectors app, running boot
// - Busy flag always reads zero
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module bplk_protect
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Register port.
  input wire bplk_pkg::bplk_bus_req_type bus,
  output logic [7:0] rdata,
  // Core program-memory accesses.
  input wire bplk_pkg::bplk_core_req_type core,
  output bplk_pkg::bplk_core_resp_type resp,
  // Programming interface and nonvolatile lock cells.
  input wire logic progLockWe,
  input wire logic [3:0] progLockData,
  input wire logic chipErase,
  input wire logic [3:0] nvLock,
  output logic [3:0] lockNv
);
  import bplk_pkg::*;

  typedef struct packed {
    logic [3:0] lock;
    logic [7:0] lockData;
    logic [7:0] rdata;
    bplk_core_resp_type resp;
  } bplk_state_type;

  bplk_state_type st;
  bplk_state_type next_st;
  logic [4:0] winCmd;
  logic winActive;
  logic ctrlWe;
  logic consume;
  logic [3:0] lockReq;

  // ----------------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------------
  // True when a byte address falls in the boot loader section.
  function automatic logic inBoot(input logic [14:0] addr);
    inBoot = (addr >= BOOT_START);
  endfunction : inBoot

  // True when stores into the chosen section are refused.
  function automatic logic wrLocked(input logic [3:0] lk, input logic boot);
    wrLocked = boot ? !lk[LK_BOOT_WR] : !lk[LK_APP_WR];
  endfunction : wrLocked

  // True when a load crossing into the target section must be denied.
  function automatic logic loadDenied(input logic [3:0] lk,
                                      input logic pcBoot,
                                      input logic tgtBoot);
    if (pcBoot == tgtBoot)
      loadDenied = 1'b0;
    else
      loadDenied = tgtBoot ? !lk[LK_BOOT_RD] : !lk[LK_APP_RD];
  endfunction : loadDenied

  // ----------------------------------------------------------------------
  // Command window.
  // ----------------------------------------------------------------------
  // The window module owns the control register bits and their
  // four-cycle lifetime; a store consumes whatever is armed.
  assign ctrlWe = bus.we && (bus.addr == REG_CTRL);
  assign consume = core.store && winActive;
  // Lock-set bits as a store would apply them; kept as one named signal
  // so that the lock-set check can look back at the value it used.
  assign lockReq = st.lockData[LOCK_DATA_MSB:LOCK_DATA_LSB];

  bplk_spm_window u_window (
    .mclk(mclk),
    .srst(srst),
    .ctrlWe(ctrlWe),
    .ctrlData(bus.wdata[4:0]),
    .consume(consume),
    .cmd(winCmd),
    .active(winActive)
  );

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  // Response flags are one-cycle pulses except the interrupt mask, which
  // follows the executing section every cycle.
  always_comb
  begin
    next_st = st;
    next_st.resp = '0;
    next_st.rdata = RDATA_IDLE;
    // Register reads; read data stand only in the cycle after the strobe.
    if (bus.re)
    begin
      case (bus.addr)
        REG_CTRL:
          next_st.rdata = {3'h0, winCmd};
        REG_LOCKDATA:
          next_st.rdata = st.lockData;
        REG_LOCKSTAT:
          next_st.rdata = {LOCK_PAD, st.lock, LOCK_PAD};
        default:
          next_st.rdata = RDATA_IDLE;
      endcase
    end
    if (bus.we && bus.addr == REG_LOCKDATA)
      next_st.lockData = bus.wdata;
    // Stores inside an armed window.
    if (consume)
    begin
      case (winCmd)
        CMD_ERASE, CMD_WRITE:
        begin
          // Refused stores raise no flash strobe at all.
          if (wrLocked(st.lock, inBoot(core.addr)))
            next_st.resp.storeBlocked = 1'b1;
          else if (winCmd == CMD_ERASE)
            next_st.resp.flashErase = 1'b1;
          else
            next_st.resp.flashWrite = 1'b1;
        end
        CMD_FILL:
          next_st.resp.fillBuf = 1'b1;
        CMD_LOCKSET:
          // AND keeps programming one way; each bit moves alone.
          next_st.lock = st.lock & lockReq;
        CMD_REENABLE:
          // Accepted for compatibility only; the section is always
          // readable here, so nothing else changes.
          next_st.resp = '0;
        default:
          next_st.resp = '0;
      endcase
    end
    // Loads: crossing reads into a read-locked section are denied.
    if (core.load)
    begin
      if (loadDenied(st.lock, core.pcInBoot, inBoot(core.addr)))
        next_st.resp.loadBlocked = 1'b1;
      else
        next_st.resp.loadOk = 1'b1;
    end
    // Interrupt masking when vectors sit in the other side and the executing side is read-locked.
    next_st.resp.intBlock =
      (core.vecInBoot && !core.pcInBoot && !st.lock[LK_APP_RD]) ||
      (!core.vecInBoot && core.pcInBoot && !st.lock[LK_BOOT_RD]);
    // Programming interface may only program further.
    if (progLockWe)
      next_st.lock = next_st.lock & progLockData;
    // Chip erase is the only way back to unprogrammed.
    if (chipErase)
      next_st.lock = LOCK_ERASED;
    // Reset reloads the locks from the nonvolatile cells, never erases.
    if (srst)
    begin
      next_st.lock = nvLock;
      next_st.lockData = LOCKDATA_RESET;
      next_st.rdata = RDATA_IDLE;
      next_st.resp = '0;
    end
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign rdata = st.rdata;
  assign resp = st.resp;
  assign lockNv = st.lock;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  sequence seqFlashOp;
    core.store && winActive && (winCmd == CMD_ERASE || winCmd == CMD_WRITE);
  endsequence

  sequence seqAppOp;
    seqFlashOp and !inBoot(core.addr);
  endsequence

  sequence seqBootOp;
    seqFlashOp and inBoot(core.addr);
  endsequence

  sequence seqArmNoStore;
    (ctrlWe && bus.wdata[BIT_SPMEN]) ##1 (!core.store && !ctrlWe) [*4];
  endsequence

  sequence seqLockSet;
    core.store && winActive && winCmd == CMD_LOCKSET;
  endsequence

  sequence seqReenable;
    core.store && winActive && winCmd == CMD_REENABLE;
  endsequence

  // Stores: a write lock must turn the flash strobe into a refusal.
  a_app_write_block: assert property (
    @(posedge mclk) disable iff (srst)
    seqAppOp and !st.lock[LK_APP_WR] |=>
      resp.storeBlocked && !resp.flashErase && !resp.flashWrite)
    else $error("store to write-locked application section passed");

  a_boot_write_block: assert property (
    @(posedge mclk) disable iff (srst)
    seqBootOp and !st.lock[LK_BOOT_WR] |=>
      resp.storeBlocked && !resp.flashErase && !resp.flashWrite)
    else $error("store to write-locked boot section passed");

  a_app_open_mode: assert property (
    @(posedge mclk) disable iff (srst)
    seqAppOp and (st.lock[LK_APP_RD:LK_APP_WR] == 2'h3) |=>
      (resp.flashErase || resp.flashWrite) && !resp.storeBlocked)
    else $error("unlocked application store was refused");

  a_boot_open_mode: assert property (
    @(posedge mclk) disable iff (srst)
    seqBootOp and (st.lock[LK_BOOT_RD:LK_BOOT_WR] == 2'h3) |=>
      (resp.flashErase || resp.flashWrite) && !resp.storeBlocked)
    else $error("unlocked boot store was refused");

  // A refusal never travels together with a flash strobe.
  a_blocked_no_strobe: assert property (
    @(posedge mclk) disable iff (srst)
    resp.storeBlocked |-> !resp.flashErase && !resp.flashWrite)
    else $error("refused store still raised a flash strobe");

  // Stores that find no armed window must leave no trace at all.
  a_stale_store_quiet: assert property (
    @(posedge mclk) disable iff (srst)
    core.store && !winActive |=> !resp.flashErase && !resp.flashWrite &&
      !resp.storeBlocked && !resp.fillBuf)
    else $error("store outside the command window had an effect");

  a_reenable_quiet: assert property (
    @(posedge mclk) disable iff (srst)
    seqReenable and (!progLockWe && !chipErase) |=>
      !resp.flashErase && !resp.flashWrite && !resp.storeBlocked &&
      !resp.fillBuf && lockNv == $past(lockNv))
    else $error("re-enable command changed flash or lock state");

  // Loads: only a crossing read into a read-locked section is denied.
  a_app_read_block: assert property (
    @(posedge mclk) disable iff (srst)
    core.load && core.pcInBoot && !inBoot(core.addr) &&
      !st.lock[LK_APP_RD] |=> resp.loadBlocked && !resp.loadOk)
    else $error("boot load read a read-locked application section");

  a_boot_read_block: assert property (
    @(posedge mclk) disable iff (srst)
    core.load && !core.pcInBoot && inBoot(core.addr) &&
      !st.lock[LK_BOOT_RD] |=> resp.loadBlocked && !resp.loadOk)
    else $error("application load read a read-locked boot section");

  a_load_same_side: assert property (
    @(posedge mclk) disable iff (srst)
    core.load && (core.pcInBoot == inBoot(core.addr)) |=>
      resp.loadOk && !resp.loadBlocked)
    else $error("load within its own section was denied");

  // Interrupt mask follows the executing section one cycle late.
  a_int_app_mask: assert property (
    @(posedge mclk) disable iff (srst)
    core.vecInBoot && !core.pcInBoot && !st.lock[LK_APP_RD] &&
      !progLockWe && !chipErase |=> resp.intBlock)
    else $error("interrupts not masked in application code");

  a_int_boot_mask: assert property (
    @(posedge mclk) disable iff (srst)
    !core.vecInBoot && core.pcInBoot && !st.lock[LK_BOOT_RD] |=>
      resp.intBlock)
    else $error("interrupts not masked in boot loader code");

  // Lock moves: both programming paths only clear bits, erase sets all.
  a_lock_one_way: assert property (
    @(posedge mclk) disable iff (srst)
    !$past(chipErase) |-> (lockNv & ~$past(lockNv)) == 4'h0)
    else $error("lock bit returned to unprogrammed without chip erase");

  a_lock_set_and: assert property (
    @(posedge mclk) disable iff (srst)
    seqLockSet and (!progLockWe && !chipErase) |=>
      lockNv == ($past(lockNv) & $past(lockReq)))
    else $error("lock-set store did not apply the lock data bits");

  a_prog_port_and: assert property (
    @(posedge mclk) disable iff (srst)
    progLockWe && !chipErase && !consume |=>
      lockNv == ($past(lockNv) & $past(progLockData)))
    else $error("programming port did not apply its lock bits");

  a_erase_clears: assert property (
    @(posedge mclk) disable iff (srst)
    chipErase |=> lockNv == LOCK_ERASED)
    else $error("chip erase left a lock bit programmed");

  a_busy_reads_zero: assert property (
    @(posedge mclk) disable iff (srst)
    bus.re && bus.addr == REG_CTRL |=> !rdata[BIT_BUSY])
    else $error("busy flag read as one");

  a_window_expires: assert property (
    @(posedge mclk) disable iff (srst)
    seqArmNoStore |=> !winActive && winCmd == CMD_NONE)
    else $error("command window outlived four cycles");

endmodule : bplk_protect

/* include/bplk_pkg.sv */
package bplk_pkg;

  // ----------------------------------------------------------------------
  // Register map of the plain register port.
  // ----------------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_LOCKDATA = 2'h1;
  localparam logic [1:0] REG_LOCKSTAT = 2'h2;

  // ----------------------------------------------------------------------
  // Control register fields and command patterns (low five bits).
  // ----------------------------------------------------------------------
  localparam int BIT_SPMEN = 0;
  localparam int BIT_BUSY = 6;
  localparam logic [4:0] CMD_NONE = 5'h00;
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;

  // ----------------------------------------------------------------------
  // Lock bits: 1 is unprogrammed, 0 is programmed.
  // ----------------------------------------------------------------------
  localparam int LK_APP_WR = 0;
  localparam int LK_APP_RD = 1;
  localparam int LK_BOOT_WR = 2;
  localparam int LK_BOOT_RD = 3;
  localparam int LOCK_DATA_LSB = 2;
  localparam int LOCK_DATA_MSB = 5;
  localparam logic [3:0] LOCK_ERASED = 4'hf;
  localparam logic [7:0] LOCKDATA_RESET = 8'hff;
  localparam logic [1:0] LOCK_PAD = 2'h3;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ----------------------------------------------------------------------
  // Timing and memory layout.
  // ----------------------------------------------------------------------
  localparam logic [2:0] WINDOW_CYC = 3'h4;
  localparam logic [14:0] BOOT_START = 15'h7000;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BPLK_IDLE = 2'b01,
    BPLK_ARMED = 2'b10
  } bplk_win_state_type;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bplk_bus_req_type;

  typedef struct packed {
    logic store;
    logic load;
    logic [14:0] addr;
    logic pcInBoot;
    logic vecInBoot;
  } bplk_core_req_type;

  typedef struct packed {
    logic flashErase;
    logic flashWrite;
    logic fillBuf;
    logic storeBlocked;
    logic loadOk;
    logic loadBlocked;
    logic intBlock;
  } bplk_core_resp_type;

endpackage : bplk_pkg

/* design/bplk_spm_window.sv */
`timescale 1ns/1ns
module bplk_spm_window
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Control register write and store consumption.
  input wire logic ctrlWe,
  input wire logic [4:0] ctrlData,
  input wire logic consume,
  // Armed command.
  output logic [4:0] cmd,
  output logic active
);
  import bplk_pkg::*;

  typedef struct packed {
    bplk_win_state_type state;
    logic [4:0] cmd;
    logic [2:0] left;
  } bplk_win_type;

  bplk_win_type st;
  bplk_win_type next_st;

  // ----------------------------------------------------------------------
  // Command window.
  // ----------------------------------------------------------------------
  // A command only arms when its enable bit is set; otherwise the write
  // simply disarms, so a stale command can never fire later.
  always_comb
  begin
    next_st = st;
    case (st.state)
      BPLK_IDLE:
      begin
        next_st.cmd = CMD_NONE;
      end
      BPLK_ARMED:
      begin
        if (consume || st.left == 3'h1)
        begin
          next_st.state = BPLK_IDLE;
          next_st.cmd = CMD_NONE;
        end
        next_st.left = st.left - 3'h1;
      end
      default:
      begin
        next_st.state = BPLK_IDLE;
        next_st.cmd = CMD_NONE;
      end
    endcase
    if (ctrlWe)
    begin
      next_st.cmd = ctrlData[BIT_SPMEN] ? ctrlData : CMD_NONE;
      next_st.state = ctrlData[BIT_SPMEN] ? BPLK_ARMED : BPLK_IDLE;
      next_st.left = WINDOW_CYC;
    end
    if (srst)
    begin
      next_st.state = BPLK_IDLE;
      next_st.cmd = CMD_NONE;
      next_st.left = 3'h0;
    end
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign cmd = st.cmd;
  assign active = (st.state == BPLK_ARMED);

endmodule : bplk_spm_window

/* verif/bplk_core_model.sv */
`timescale 1ns/1ns
module bplk_core_model
(
  // Clock.
  input wire logic mclk,
  // Program-memory requests.
  output bplk_pkg::bplk_core_req_type core
);
  import bplk_pkg::*;

  // Quiet core: no access, address zero, code and vectors both in the application section.
  initial
  begin
    core = '0;
  end

  // One access, then one free edge so that strobes never collide.
  // The address is inverted on release so stale values never look live.
  task automatic access(input logic isStore, input logic [14:0] a);
    core.store <= isStore;
    core.load <= !isStore;
    core.addr <= a;
    @(posedge mclk);
    core.store <= 1'b0;
    core.load <= 1'b0;
    core.addr <= ~a;
    @(posedge mclk);
  endtask : access

  // Where code runs and where the vectors sit, both levels.
  task automatic setMode(input logic pc, input logic vec);
    core.pcInBoot <= pc;
    core.vecInBoot <= vec;
  endtask : setMode
endmodule : bplk_core_model

/* verif/bplk_protect_bench.sv */
`timescale 1ns/1ns
module bplk_protect_bench;
  import bplk_pkg::*;
  // --------------------------------------------------------------------
  // Signals and counters.
  // --------------------------------------------------------------------
  logic mclk;
  logic srst;
  bplk_bus_req_type bus;
  logic [7:0] rdata;
  bplk_core_req_type core;
  bplk_core_resp_type resp;
  logic progLockWe;
  logic [3:0] progLockData;
  logic chipErase;
  logic [3:0] nvLock;
  logic [3:0] lockNv;
  logic [3:0] lk;
  logic rdV;
  logic [31:0] seed;
  logic [13:0] notes[$];
  int errTotal;
  int nChecks;

  bplk_protect u_dut (
    .mclk(mclk),
    .srst(srst),
    .bus(bus),
    .rdata(rdata),
    .core(core),
    .resp(resp),
    .progLockWe(progLockWe),
    .progLockData(progLockData),
    .chipErase(chipErase),
    .nvLock(nvLock),
    .lockNv(lockNv)
  );

  bplk_core_model u_core (
    .mclk(mclk),
    .core(core)
  );

  // Free-running core clock, 100 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // --------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reportAndStop;
    if (errTotal == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : reportAndStop

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Bus cycles end with a free edge, so a strobe is never set twice.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.we <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    notes.push_back({e, 6'h00});
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus.re <= 1'b0;
    @(posedge mclk);
  endtask : rd

  // A zero code means the store must produce no pulse at all.
  task automatic st(input logic [14:0] a, input logic [5:0] e);
    if (e != 6'h00)
      notes.push_back({8'h00, e});
    u_core.access(1'b1, a);
  endtask : st

  task automatic ld(input logic [14:0] a, input logic pc, input logic vec);
    logic tb;
    logic ib;
    tb = (a >= BOOT_START);
    ib = (vec & !pc & !lk[1]) | (!vec & pc & !lk[3]);
    u_core.setMode(pc, vec);
    notes.push_back((tb != pc && !lk[tb ? 3 : 1]) ? 14'h1 : 14'h2);
    u_core.access(1'b0, a);
    @(negedge mclk);
    chk({13'h0, resp.intBlock}, {13'h0, ib});
    @(posedge mclk);
  endtask : ld

  task automatic plock(input logic [3:0] d);
    progLockWe <= 1'b1;
    progLockData <= d;
    @(posedge mclk);
    progLockWe <= 1'b0;
    lk = lk & d;
    @(posedge mclk);
  endtask : plock

  task automatic erase;
    chipErase <= 1'b1;
    @(posedge mclk);
    chipErase <= 1'b0;
    lk = 4'hf;
    @(posedge mclk);
  endtask : erase

  task automatic lockIs(input logic [3:0] e);
    @(negedge mclk);
    chk({10'h0, lockNv}, {10'h0, e});
    @(posedge mclk);
  endtask : lockIs

  // Results are matched in order against the oldest note.
  always @(posedge mclk)
    rdV <= bus.re;

  always @(negedge mclk)
    if (!srst && (rdV || resp[6:1] !== 6'h00))
    begin
      if (notes.size() == 0)
        chk({rdata, resp[6:1]}, 14'h0);
      else
        chk({rdata, resp[6:1]}, notes.pop_front());
    end

  // A hang is cut short here and counted as a mismatch.
  initial
  begin
    repeat (5000) @(posedge mclk);
    errTotal++;
    reportAndStop;
  end

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    bus = '0;
    progLockWe = 1'b0;
    progLockData = 4'hf;
    chipErase = 1'b0;
    nvLock = 4'h5;
    lk = 4'h5;
    errTotal = 0;
    nChecks = 0;
    seed = 32'h00011e93;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    lockIs(4'h5);
    rd(REG_LOCKSTAT, 8'hd7);
    erase;
    lockIs(4'hf);
    wr(REG_CTRL, 8'h03);
    st(15'h0100, 6'h20);
    wr(REG_CTRL, 8'h05);
    st(15'h7100, 6'h10);
    wr(REG_CTRL, 8'h01);
    st(15'h0102, 6'h08);
    wr(REG_CTRL, 8'h11);
    rd(REG_CTRL, 8'h11);
    st(15'h0000, 6'h00);
    rd(REG_CTRL, 8'h00);
    rd(2'h3, 8'h00);
    wr(REG_LOCKSTAT, 8'h00);
    rd(REG_LOCKSTAT, 8'hff);
    // Last cycle of the window, then one cycle too late.
    wr(REG_CTRL, 8'h03);
    idle(2);
    st(15'h0200, 6'h20);
    wr(REG_CTRL, 8'h03);
    idle(3);
    st(15'h0200, 6'h00);
    // Write locks, set one field at a time by both paths.
    plock(4'he);
    lockIs(4'he);
    wr(REG_CTRL, 8'h03);
    st(15'h0300, 6'h04);
    wr(REG_CTRL, 8'h03);
    st(15'h7300, 6'h20);
    wr(REG_LOCKDATA, 8'hef);
    wr(REG_CTRL, 8'h09);
    st(15'h0000, 6'h00);
    lk = lk & 4'hb;
    lockIs(4'ha);
    wr(REG_CTRL, 8'h05);
    st(15'h7400, 6'h04);
    plock(4'hf);
    lockIs(4'ha);
    // Every read-lock mode with random loads and modes.
    for (int m = 0; m < 4; m++)
    begin
      erase;
      plock({m[1], 1'b1, m[0], 1'b1});
      for (int i = 0; i < 8; i++)
      begin
        seed = lfsr(seed);
        ld({seed[2] ? 3'h7 : 3'h0, seed[14:3]}, seed[0], seed[1]);
      end
    end
    // A second reset reloads the cells and erases nothing.
    srst <= 1'b1;
    nvLock <= 4'h9;
    idle(2);
    srst <= 1'b0;
    lk = 4'h9;
    lockIs(4'h9);
    ld(15'h0010, 1'b1, 1'b0);
    idle(3);
    chk(14'(notes.size()), 14'h0);
    reportAndStop;
  end
endmodule : bplk_protect_bench
